// ===== shared/rsc_pkg.sv
// Constants and types for the reset initial state control block.
// Assumes one 10 MHz system clock and reset sources that share that clock.
`default_nettype none

package rsc_pkg;

	// System clock
	localparam int unsigned CLK_HZ = 10_000_000;

	// Widths
	localparam int unsigned REG_W = 8;
	localparam int unsigned CNT_W = 16;
	localparam int unsigned SP_W  = 3;
	localparam int unsigned SEL_W = 3;

	// Stack pointer after a power-on or normal watchdog reset (top of stack)
	localparam logic [SP_W-1:0] SP_TOP  = 3'h0;
	localparam logic [SP_W-1:0] SP_ZERO = 3'h0;

	// Initial register values for power-on and normal watchdog reset
	localparam logic [REG_W-1:0] INTC_INIT  = 8'h00;
	localparam logic [REG_W-1:0] TMR_INIT   = 8'h00;
	localparam logic [REG_W-1:0] WDTC_INIT  = 8'h53;
	localparam logic [REG_W-1:0] LVRC_INIT  = 8'h66;
	localparam logic [REG_W-1:0] PAC_INIT   = 8'hFF;
	localparam logic [REG_W-1:0] PBC_INIT   = 8'h7F;
	localparam logic [REG_W-1:0] PBC_MASK   = 8'h7F;
	localparam logic [CNT_W-1:0] CNT_ZERO   = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE    = 16'h0001;

	// Register selector codes of the core write port
	localparam logic [SEL_W-1:0] SEL_INTC = 3'h0;
	localparam logic [SEL_W-1:0] SEL_TMR  = 3'h1;
	localparam logic [SEL_W-1:0] SEL_WDTC = 3'h2;
	localparam logic [SEL_W-1:0] SEL_LVRC = 3'h3;
	localparam logic [SEL_W-1:0] SEL_PAC  = 3'h4;
	localparam logic [SEL_W-1:0] SEL_PBC  = 3'h5;

	// Kind of the last reset
	localparam logic [1:0] KIND_POR      = 2'h0;
	localparam logic [1:0] KIND_LVR      = 2'h1;
	localparam logic [1:0] KIND_WDT_RUN  = 2'h2;
	localparam logic [1:0] KIND_WDT_IDLE = 2'h3;

	// Sequencer phase
	typedef enum logic [1:0] {
		ST_START = 2'b01,
		ST_RUN   = 2'b10
	} rsc_phase_t;

	// Configuration registers that take per-reset-kind values
	typedef struct packed {
		logic [REG_W-1:0] intc;
		logic [REG_W-1:0] tmr;
		logic [REG_W-1:0] wdtc;
		logic [REG_W-1:0] lvrc;
		logic [REG_W-1:0] pac;
		logic [REG_W-1:0] pbc;
	} rsc_regs_t;

	localparam rsc_regs_t REGS_INIT = '{
		intc: INTC_INIT, tmr: TMR_INIT, wdtc: WDTC_INIT,
		lvrc: LVRC_INIT, pac: PAC_INIT, pbc: PBC_INIT};

	// Whole state of the block
	typedef struct packed {
		rsc_phase_t       phase;
		logic             timeout_flag;
		logic             power_down_flag;
		logic             low_power;
		logic [CNT_W-1:0] wdt_cnt;
		logic [CNT_W-1:0] tb_cnt;
		logic [SP_W-1:0]  sp;
		logic             pc_clear;
		logic [1:0]       kind;
		rsc_regs_t        regs;
	} rsc_state_t;

endpackage

`default_nettype wire

// ===== hdl/rsc_top.sv
// Reset initial state control: reset-cause flags and per-kind initial state.
// Assumes all event inputs come from logic on clk_i; reset_n_i is power-on.
//
// What this block does
// - Keep timeout and power-down flags, altered by sleep/watchdog.
// - Power-on reset clears both flags.
// - Low-voltage reset leaves both flags unchanged.
// - Running watchdog reset sets timeout, keeps power-down.
// - Idle/sleep watchdog reset sets both flags.
// - Power-on reset disables every interrupt source.
// - Power-on clears watchdog and time bases; watchdog counts.
// - Power-on reset switches the timer off; watchdog and time base run.
// - Power-on reset makes all I/O pins inputs.
// - Power-on reset puts stack pointer at top.
// - Registers load initial values chosen by reset kind.
// - Power-on reset starts fetch at address zero.
// - Idle watchdog reset zeroes PC, SP, watchdog count; keeps registers and time base.
`default_nettype none

module rsc_top
	import rsc_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             reset_n_i,
	input  wire logic             lvr_reset_i,
	input  wire logic             wdt_timeout_i,
	input  wire logic             sleep_enter_i,
	input  wire logic             wake_i,
	input  wire logic             wdt_clear_i,
	input  wire logic             wr_en_i,
	input  wire logic [SEL_W-1:0] wr_sel_i,
	input  wire logic [REG_W-1:0] wr_data_i,
	output logic                  timeout_flag_o,
	output logic                  power_down_flag_o,
	output logic                  low_power_o,
	output logic                  pc_clear_o,
	output logic [SP_W-1:0]       stack_ptr_o,
	output logic [CNT_W-1:0]      wdt_count_o,
	output logic [CNT_W-1:0]      time_base_o,
	output logic [1:0]            reset_kind_o,
	output logic [REG_W-1:0]      int_enable_o,
	output logic [REG_W-1:0]      timer_ctrl_o,
	output logic [REG_W-1:0]      wdt_ctrl_o,
	output logic [REG_W-1:0]      lvr_ctrl_o,
	output logic [REG_W-1:0]      pa_dir_o,
	output logic [REG_W-1:0]      pb_dir_o
);

	////////////////////////////////////////////////////////////////////////////////
	// State

	rsc_state_t st_r;
	rsc_state_t st_nxt;

	localparam rsc_state_t ST_RESET = '{
		phase: ST_START, timeout_flag: 1'b0, power_down_flag: 1'b0,
		low_power: 1'b0, wdt_cnt: CNT_ZERO, tb_cnt: CNT_ZERO, sp: SP_TOP,
		pc_clear: 1'b1, kind: KIND_POR, regs: REGS_INIT};

	// Next counter value, wrapping
	function automatic logic [CNT_W-1:0] cnt_inc(input logic [CNT_W-1:0] c);
		cnt_inc = c + CNT_ONE;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic

	logic wdt_run_rst;
	logic wdt_idle_rst;
	logic lvr_rst;
	logic any_rst;

	// Reset events; watchdog wins over low voltage in the same cycle
	assign wdt_run_rst  = wdt_timeout_i && !st_r.low_power;
	assign wdt_idle_rst = wdt_timeout_i && st_r.low_power;
	assign lvr_rst      = lvr_reset_i && !wdt_timeout_i && !st_r.low_power;
	assign any_rst      = wdt_timeout_i || lvr_rst;

	always_comb begin
		st_nxt          = st_r;
		st_nxt.phase    = ST_RUN;
		st_nxt.pc_clear = 1'b0;
		st_nxt.wdt_cnt  = cnt_inc(st_r.wdt_cnt);
		st_nxt.tb_cnt   = cnt_inc(st_r.tb_cnt);

		// Core writes to the configuration registers
		if (wr_en_i) begin
			case (wr_sel_i)
				SEL_INTC: st_nxt.regs.intc = wr_data_i;
				SEL_TMR:  st_nxt.regs.tmr  = wr_data_i;
				SEL_WDTC: st_nxt.regs.wdtc = wr_data_i;
				SEL_LVRC: st_nxt.regs.lvrc = wr_data_i;
				SEL_PAC:  st_nxt.regs.pac  = wr_data_i;
				SEL_PBC:  st_nxt.regs.pbc  = wr_data_i & PBC_MASK;
				default:  st_nxt.regs      = st_r.regs;
			endcase
		end

		// Flag updates from low-power entry and watchdog clear
		if (sleep_enter_i) begin
			st_nxt.timeout_flag    = 1'b0;
			st_nxt.power_down_flag = 1'b1;
			st_nxt.low_power       = 1'b1;
			st_nxt.wdt_cnt         = CNT_ZERO;
		end else if (wdt_clear_i) begin
			st_nxt.timeout_flag    = 1'b0;
			st_nxt.power_down_flag = 1'b0;
			st_nxt.wdt_cnt         = CNT_ZERO;
		end else if (wake_i) begin
			st_nxt.low_power = 1'b0;
		end

		// Watchdog reset while idle or asleep: most state kept
		if (wdt_idle_rst) begin
			st_nxt.timeout_flag    = 1'b1;
			st_nxt.power_down_flag = 1'b1;
			st_nxt.sp              = SP_ZERO;
			st_nxt.pc_clear        = 1'b1;
			st_nxt.regs            = st_r.regs;
			st_nxt.low_power       = 1'b0;
			st_nxt.kind            = KIND_WDT_IDLE;
		end else if (wdt_run_rst || lvr_rst) begin
			// Running watchdog and low-voltage resets share the normal values
			st_nxt.timeout_flag    = wdt_run_rst ? 1'b1 : st_r.timeout_flag;
			st_nxt.power_down_flag = st_r.power_down_flag;
			st_nxt.sp              = SP_TOP;
			st_nxt.pc_clear        = 1'b1;
			st_nxt.regs            = REGS_INIT;
			st_nxt.tb_cnt          = CNT_ZERO;
			st_nxt.kind            = wdt_run_rst ? KIND_WDT_RUN : KIND_LVR;
		end
		if (any_rst) begin
			st_nxt.wdt_cnt = CNT_ZERO;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register; power-on values: flags 0, interrupts off, timer off,
	// pins inputs, stack at top, counters cleared, fetch from zero

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_r <= ST_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign timeout_flag_o    = st_r.timeout_flag;
	assign power_down_flag_o = st_r.power_down_flag;
	assign low_power_o       = st_r.low_power;
	assign pc_clear_o        = st_r.pc_clear;
	assign stack_ptr_o       = st_r.sp;
	assign wdt_count_o       = st_r.wdt_cnt;
	assign time_base_o       = st_r.tb_cnt;
	assign reset_kind_o      = st_r.kind;
	assign int_enable_o      = st_r.regs.intc;
	assign timer_ctrl_o      = st_r.regs.tmr;
	assign wdt_ctrl_o        = st_r.regs.wdtc;
	assign lvr_ctrl_o        = st_r.regs.lvrc;
	assign pa_dir_o          = st_r.regs.pac;
	assign pb_dir_o          = st_r.regs.pbc;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	property p_por_state;
		@(posedge clk_i) disable iff (!reset_n_i)
		st_r.phase == ST_START |-> !timeout_flag_o && !power_down_flag_o
			&& pc_clear_o && reset_kind_o == KIND_POR;
	endproperty
	a_por_state: assert property (p_por_state) else $error("power-on state wrong");

	property p_por_regs;
		@(posedge clk_i) disable iff (!reset_n_i)
		st_r.phase == ST_START |-> int_enable_o == INTC_INIT && timer_ctrl_o == TMR_INIT
			&& pa_dir_o == PAC_INIT && stack_ptr_o == SP_TOP;
	endproperty
	a_por_regs: assert property (p_por_regs) else $error("power-on registers wrong");

	property p_wdt_counts;
		@(posedge clk_i) disable iff (!reset_n_i)
		!(any_rst || sleep_enter_i || wdt_clear_i) |=> wdt_count_o == cnt_inc($past(wdt_count_o));
	endproperty
	a_wdt_counts: assert property (p_wdt_counts) else $error("watchdog not counting");

	property p_wdt_run;
		@(posedge clk_i) disable iff (!reset_n_i)
		wdt_run_rst |=> timeout_flag_o && power_down_flag_o == $past(power_down_flag_o)
			&& int_enable_o == INTC_INIT && reset_kind_o == KIND_WDT_RUN;
	endproperty
	a_wdt_run: assert property (p_wdt_run) else $error("running watchdog reset wrong");

	property p_wdt_idle;
		@(posedge clk_i) disable iff (!reset_n_i)
		wdt_idle_rst |=> timeout_flag_o && power_down_flag_o && stack_ptr_o == SP_ZERO
			&& pc_clear_o && !low_power_o;
	endproperty
	a_wdt_idle: assert property (p_wdt_idle) else $error("idle watchdog reset wrong");

	property p_idle_keeps;
		@(posedge clk_i) disable iff (!reset_n_i)
		wdt_idle_rst |=> pa_dir_o == $past(pa_dir_o) && wdt_ctrl_o == $past(wdt_ctrl_o);
	endproperty
	a_idle_keeps: assert property (p_idle_keeps) else $error("idle reset changed state");

	property p_lvr_flags;
		@(posedge clk_i) disable iff (!reset_n_i)
		lvr_rst |=> timeout_flag_o == $past(timeout_flag_o)
			&& power_down_flag_o == $past(power_down_flag_o) && lvr_ctrl_o == LVRC_INIT;
	endproperty
	a_lvr_flags: assert property (p_lvr_flags) else $error("low-voltage reset flags wrong");

	property p_sleep_flags;
		@(posedge clk_i) disable iff (!reset_n_i)
		sleep_enter_i && !wdt_timeout_i && !lvr_rst |=> power_down_flag_o && !timeout_flag_o
			##1 (sleep_enter_i || wdt_clear_i || any_rst || power_down_flag_o);
	endproperty
	a_sleep_flags: assert property (p_sleep_flags) else $error("sleep entry flags wrong");

	property p_pc_pulse;
		@(posedge clk_i) disable iff (!reset_n_i)
		pc_clear_o && !$past(any_rst) |-> st_r.phase == ST_START;
	endproperty
	a_pc_pulse: assert property (p_pc_pulse) else $error("stray program counter clear");

endmodule

`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the reset initial state control block.
// Assumes rsc_top alone on a 10 MHz clock, with assertions inside the design.
`default_nettype none

module tb_top
	import rsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic             clk, reset_n_i, wdt_i, lvr_i, slp_i, wake_i, clr_i, wr_en_i;
	logic [SEL_W-1:0] wr_sel_i;
	logic [REG_W-1:0] wr_data_i;
	logic             to_o, pdf_o, lp_o, pc_clear_o;
	logic [SP_W-1:0]  sp_o;
	logic [CNT_W-1:0] wdt_cnt_o, tb_cnt_o;
	logic [1:0]       kind_o;
	rsc_regs_t        regs_o;
	logic             m_to, m_pdf, m_lp;
	logic [1:0]       m_kind;
	logic [CNT_W-1:0] m_cnt;
	rsc_regs_t        m_regs;
	int               bad_count, comparisons;
	logic [2:0]       op;

	rsc_top u_rsc_top (.clk_i(clk), .reset_n_i(reset_n_i), .lvr_reset_i(lvr_i),
		.wdt_timeout_i(wdt_i), .sleep_enter_i(slp_i), .wake_i(wake_i), .wdt_clear_i(clr_i),
		.wr_en_i(wr_en_i), .wr_sel_i(wr_sel_i), .wr_data_i(wr_data_i), .timeout_flag_o(to_o),
		.power_down_flag_o(pdf_o), .low_power_o(lp_o), .pc_clear_o(pc_clear_o),
		.stack_ptr_o(sp_o), .wdt_count_o(wdt_cnt_o), .time_base_o(tb_cnt_o),
		.reset_kind_o(kind_o), .int_enable_o(regs_o.intc), .timer_ctrl_o(regs_o.tmr),
		.wdt_ctrl_o(regs_o.wdtc), .lvr_ctrl_o(regs_o.lvrc), .pa_dir_o(regs_o.pac),
		.pb_dir_o(regs_o.pbc));

	// Clock of 100 ns period
	always #50 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////////
	// Comparison and verdict
	task automatic check(input logic [47:0] got, input logic [47:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic finish_test;
		if (bad_count == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Expected register file after a core write
	function automatic rsc_regs_t wr_reg(input rsc_regs_t r, input logic [2:0] s,
			input logic [7:0] d);
		case (s)
			SEL_INTC: r.intc = d;
			SEL_TMR:  r.tmr = d;
			SEL_WDTC: r.wdtc = d;
			SEL_LVRC: r.lvrc = d;
			SEL_PAC:  r.pac = d;
			SEL_PBC:  r.pbc = d & PBC_MASK;
			default:  r = r;
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Power-on reset, held for n edges, then the first edge after release
	task automatic do_reset(input int n);
		{wdt_i, lvr_i, slp_i, wake_i, clr_i, wr_en_i} = 6'h00;
		reset_n_i = 1'b0;
		repeat (n) @(posedge clk);
		#1;
		check({to_o, pdf_o, lp_o, kind_o}, {3'h0, KIND_POR});
		check(regs_o, REGS_INIT);
		check({pc_clear_o, sp_o, wdt_cnt_o, tb_cnt_o}, {1'b1, SP_TOP, CNT_ZERO, CNT_ZERO});
		reset_n_i = 1'b1;
		{m_to, m_pdf, m_lp, m_kind, m_regs} = {3'h0, KIND_POR, REGS_INIT};
		@(posedge clk);
		#1;
		check({pc_clear_o, wdt_cnt_o, tb_cnt_o}, {1'b0, CNT_ONE, CNT_ONE});
		m_cnt = CNT_ONE;
	endtask

	// One cycle of events, the reference update and the checks
	task automatic cycle(input logic w, l, s, k, c, e, input logic [2:0] sel,
			input logic [7:0] d);
		logic rst;
		logic idle;
		rst = w | (l & ~m_lp);
		idle = w & m_lp;
		{wdt_i, lvr_i, slp_i, wake_i, clr_i, wr_en_i} = {w, l, s, k, c, e};
		wr_sel_i = sel;
		wr_data_i = d;
		m_cnt = (rst | s | c) ? CNT_ZERO : m_cnt + CNT_ONE;
		if (w) begin
			m_to = 1'b1;
			m_kind = idle ? KIND_WDT_IDLE : KIND_WDT_RUN;
			m_pdf = m_pdf | idle;
			m_regs = idle ? m_regs : REGS_INIT;
			m_lp = 1'b0;
		end else if (rst) begin
			m_kind = KIND_LVR;
			m_regs = REGS_INIT;
		end else if (s) begin
			{m_to, m_pdf, m_lp} = 3'h3;
		end else if (c) begin
			{m_to, m_pdf} = 2'h0;
		end else if (k) begin
			m_lp = 1'b0;
		end
		if (e & ~rst) begin
			m_regs = wr_reg(m_regs, sel, d);
		end
		@(posedge clk);
		#1;
		check({to_o, pdf_o, lp_o, kind_o}, {m_to, m_pdf, m_lp, m_kind});
		check(regs_o, m_regs);
		check({pc_clear_o, wdt_cnt_o}, {rst, m_cnt});
		if (rst) begin
			check({sp_o, idle ? CNT_ZERO : tb_cnt_o}, {SP_ZERO, CNT_ZERO});
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: corner cases, then random traffic with a power-on reset halfway through
	initial begin
		clk = 1'b0;
		wr_sel_i = 3'h0;
		wr_data_i = 8'h00;
		bad_count = 0;
		comparisons = 0;
		void'($urandom(32'h6398b955));
		do_reset(12);
		for (int i = 0; i < 8; i++) begin
			cycle(0, 0, 0, 0, 0, 1, 3'(i), 8'($urandom));
		end
		cycle(0, 0, 0, 0, 0, 1, SEL_PBC, 8'hFF);
		cycle(1, 1, 0, 0, 0, 1, SEL_PAC, 8'h00);
		cycle(0, 0, 0, 0, 0, 1, SEL_PAC, 8'h00);
		cycle(0, 1, 0, 0, 0, 1, SEL_TMR, 8'h5A);
		cycle(0, 0, 1, 0, 0, 0, 3'h0, 8'h00);
		cycle(0, 1, 0, 0, 0, 0, 3'h0, 8'h00);
		cycle(1, 0, 0, 0, 0, 0, 3'h0, 8'h00);
		cycle(0, 0, 0, 0, 1, 0, 3'h0, 8'h00);
		cycle(1, 0, 0, 0, 0, 0, 3'h0, 8'h00);
		for (int i = 0; i < 3000; i++) begin
			op = 3'($urandom_range(0, 7));
			if (m_lp && op != 3'h0 && op != 3'h1) begin
				op = 3'h3;
			end
			if (i == 1500) begin
				do_reset(1);
			end
			cycle(op == 0, op == 1, op == 2, op == 3, op == 4, op > 4, 3'($urandom_range(0, 7)),
				8'($urandom));
		end
		finish_test();
	end

endmodule

`default_nettype wire
